/* pkg/timer_defs.svh */
// register offsets, reset values and counting constants of the timer block
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ************************************************************
// register offsets on the plain register port
// ************************************************************
`define ADDR_CTRL 4'h0
`define ADDR_MODE 4'h1
`define ADDR_T0_LOW 4'h2
`define ADDR_T0_HIGH 4'h3
`define ADDR_T1_LOW 4'h4
`define ADDR_T1_HIGH 4'h5
`define ADDR_T2_CTRL 4'h6
`define ADDR_T2_MODE 4'h7
`define ADDR_T2_LOW 4'h8
`define ADDR_T2_HIGH 4'h9
`define ADDR_T2_CAP_LOW 4'ha
`define ADDR_T2_CAP_HIGH 4'hb
`define ADDR_STATUS 4'hc
`define ADDR_MASK 4'hd

// ************************************************************
// values and counting constants
// ************************************************************
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define BYTE_ONE 8'h01
`define BYTE_ONES 8'hff
`define WORD_ONE 16'h0001
`define WORD_ONES 16'hffff
`define LOW5_ONE 5'h01
`define LOW5_ONES 5'h1f
`define PRESCALE_SLOW 4'hc
`define PRESCALE_FAST 4'h4
`define PRESCALE_ONE 4'h1
`define PRESCALE_ZERO 4'h0
`define PIN_IDLE 1'b1

`endif

/* pkg/timer_pkg.sv */
// types shared by the timer block and its register port
package timer_pkg;

  // ************************************************************
  // per-timer mode field, low nibble timer 0, high nibble timer 1
  // ************************************************************
  typedef enum logic [1:0] {
    mode_13bit = 2'b00,
    mode_16bit = 2'b01,
    mode_reload = 2'b10,
    mode_split = 2'b11
  } timer_mode_e;

  typedef struct packed {
    logic gate;
    logic source_pin;
    timer_mode_e mode;
  } timer_cfg_s;

  typedef struct packed {
    timer_cfg_s t1;
    timer_cfg_s t0;
  } mode_reg_s;

  // ************************************************************
  // control, timer 2 and interrupt layouts
  // ************************************************************
  typedef struct packed {
    logic t2_div4;
    logic t1_div4;
    logic t0_div4;
    logic timer1_run;
    logic timer0_run;
  } ctrl_reg_s;

  typedef struct packed {
    logic serial_receive_clock_select;
    logic serial_transmit_clock_select;
    logic trigger_enable;
    logic timer2_run;
    logic timer2_source_select;
    logic capture_reload_select;
  } t2_ctrl_s;

  typedef struct packed {
    logic timer2_clock_output_enable;
    logic down_enable;
  } t2_mode_s;

  typedef struct packed {
    logic t2_trigger;
    logic t2_overflow;
    logic timer1_overflow_flag;
    logic timer0_overflow_flag;
  } irq_s;

  typedef enum logic [1:0] {
    t2_reload = 2'b00,
    t2_capture = 2'b01,
    t2_baud = 2'b11,
    t2_clock_out = 2'b10
  } t2_func_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

/* hw/pin_sync.sv */
// two-stage synchroniser with falling-edge detect for one input pin
`timescale 1ns/1ps
`include "timer_defs.svh"
module pin_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic fall
);
  logic meta;
  logic last;

  // ************************************************************
  // synchroniser; first stage feeds only the second
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      meta <= `PIN_IDLE;
      level <= `PIN_IDLE;
      last <= `PIN_IDLE;
    end else begin
      meta <= pin;
      level <= meta;
      last <= level;
    end
  end

  // one-cycle pulse on a 1-to-0 transition
  assign fall = last & ~level;
endmodule

/* hw/prescaler.sv */
// core clock prescaler giving divide-by-slow and divide-by-fast ticks
`timescale 1ns/1ps
`include "timer_defs.svh"
module prescaler #(
  parameter logic [3:0] SLOW = `PRESCALE_SLOW,
  parameter logic [3:0] FAST = `PRESCALE_FAST
) (
  input wire logic clock,
  input wire logic rst,
  output logic tick_slow,
  output logic tick_fast
);
  logic [3:0] count_slow;
  logic [3:0] count_fast;

  // ************************************************************
  // free-running dividers; ticks are one-cycle pulses
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      count_slow <= `PRESCALE_ZERO;
      tick_slow <= 1'b0;
    end else begin
      tick_slow <= (count_slow == SLOW - `PRESCALE_ONE);
      count_slow <= (count_slow == SLOW - `PRESCALE_ONE) ? `PRESCALE_ZERO : count_slow + `PRESCALE_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count_fast <= `PRESCALE_ZERO;
      tick_fast <= 1'b0;
    end else begin
      tick_fast <= (count_fast == FAST - `PRESCALE_ONE);
      count_fast <= (count_fast == FAST - `PRESCALE_ONE) ? `PRESCALE_ZERO : count_fast + `PRESCALE_ONE;
    end
  end
endmodule

/* hw/timer_block.sv */
// three timer/counters: timers 0 and 1 (only timer 0 can split, timer 1 stops in mode 3), up/down timer 2
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "timer_defs.svh"
module timer_block (
  input wire logic clock,
  input wire logic rst,
  input wire timer_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic count_pin_zero,
  input wire logic count_pin_one,
  input wire logic count_pin_two,
  output logic count_pin_two_out,
  output logic count_pin_two_oe,
  input wire logic gate_pin_zero,
  input wire logic gate_pin_one,
  input wire logic trigger_pin_two,
  output logic timer1_baud_tick,
  output logic timer2_baud_tick,
  output logic irq
);
  import timer_pkg::*;

  ctrl_reg_s ctrl;
  mode_reg_s timer_mode_register;
  logic [7:0] t0_low, t0_high, t1_low, t1_high;
  t2_ctrl_s timer2_control_register;
  t2_mode_s timer2_mode_register;
  logic [15:0] t2_count, t2_cap;
  irq_s status, mask, events;
  logic clock_out;
  logic fall0, fall1, fall2, fall_trig;
  logic gate0_level, gate1_level, trig_level;
  logic tick_slow, tick_fast;
  logic t0_split, t0_low_go, t0_high_go, t1_run_eff, t1_go;
  logic [16:0] t0_step, t1_step;
  logic t0_flag_evt, t0_high_evt, t1_ovf_evt;
  t2_func_e t2_func;
  logic t2_go, t2_wrap, t2_trig;
  logic [15:0] next_t2_count, next_t2_cap;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic is_write(input reg_req_s req, input logic [3:0] a);
    return req.wr && req.addr == a;
  endfunction

  // run bit qualified by gate and gate pin
  function automatic logic gate_ok(input logic run, input logic gate, input logic gpin);
    return run & (~gate | gpin);
  endfunction

  // count source: pin fall or prescaled clock
  function automatic logic pick_tick(input logic src_pin, input logic div4, input logic pin_fall,
                                     input logic fast, input logic slow);
    return src_pin ? pin_fall : (div4 ? fast : slow);
  endfunction

  // one count step for modes 0, 1, 2; returns {overflow, high, low}
  function automatic logic [16:0] step(input timer_mode_e m, input logic [7:0] hi, input logic [7:0] lo);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (m)
      mode_13bit: begin
        r[4:0] = 5'(lo[4:0] + `LOW5_ONE);
        if (lo[4:0] == `LOW5_ONES) begin
          r[15:8] = 8'(hi + `BYTE_ONE);
          r[16] = (hi == `BYTE_ONES);
        end
      end
      mode_16bit: begin
        r[15:0] = 16'({hi, lo} + `WORD_ONE);
        r[16] = ({hi, lo} == `WORD_ONES);
      end
      mode_reload: begin
        r[7:0] = (lo == `BYTE_ONES) ? hi : 8'(lo + `BYTE_ONE);
        r[16] = (lo == `BYTE_ONES);
      end
      default: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  // ************************************************************
  // pin synchronisers and prescaler
  // ************************************************************
  pin_sync u_sync_c0 (.clock(clock), .rst(rst), .pin(count_pin_zero), .level(), .fall(fall0));
  pin_sync u_sync_c1 (.clock(clock), .rst(rst), .pin(count_pin_one), .level(), .fall(fall1));
  pin_sync u_sync_c2 (.clock(clock), .rst(rst), .pin(count_pin_two), .level(), .fall(fall2));
  pin_sync u_sync_g0 (.clock(clock), .rst(rst), .pin(gate_pin_zero), .level(gate0_level), .fall());
  pin_sync u_sync_g1 (.clock(clock), .rst(rst), .pin(gate_pin_one), .level(gate1_level), .fall());
  pin_sync u_sync_tr (.clock(clock), .rst(rst), .pin(trigger_pin_two), .level(trig_level), .fall(fall_trig));

  prescaler u_prescaler (.clock(clock), .rst(rst), .tick_slow(tick_slow), .tick_fast(tick_fast));

  // ************************************************************
  // timer 0 and timer 1 count enables
  // ************************************************************
  assign t0_split = timer_mode_register.t0.mode == mode_split;
  // low byte keeps all of timer 0's own controls
  assign t0_low_go = pick_tick(timer_mode_register.t0.source_pin, ctrl.t0_div4, fall0, tick_fast,
                               tick_slow)
                     & gate_ok(ctrl.timer0_run, timer_mode_register.t0.gate, gate0_level);
  // split high byte is a clock counter borrowing timer 1's run bit
  assign t0_high_go = t0_split & ctrl.timer1_run & (ctrl.t0_div4 ? tick_fast : tick_slow);
  // timer 1 loses its run bit while timer 0 is split, so it runs on gating only
  assign t1_run_eff = t0_split ? 1'b1 : ctrl.timer1_run;
  assign t1_go = (timer_mode_register.t1.mode != mode_split)
                 & pick_tick(timer_mode_register.t1.source_pin, ctrl.t1_div4, fall1, tick_fast, tick_slow)
                 & gate_ok(t1_run_eff, timer_mode_register.t1.gate, gate1_level);
  assign t0_step = step(timer_mode_register.t0.mode, t0_high, t0_low);
  assign t1_step = step(timer_mode_register.t1.mode, t1_high, t1_low);

  // overflow events
  assign t0_flag_evt = t0_split ? (t0_low_go & t0_low == `BYTE_ONES) : (t0_low_go & t0_step[16]);
  assign t0_high_evt = t0_high_go & (t0_high == `BYTE_ONES);
  assign t1_ovf_evt = t1_go & t1_step[16];

  // ************************************************************
  // timer 0 count bytes; a register write beats a count step
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      t0_low <= `RESET_BYTE;
      t0_high <= `RESET_BYTE;
    end else begin
      if (t0_split) begin
        if (t0_low_go) begin
          t0_low <= 8'(t0_low + `BYTE_ONE);
        end
        if (t0_high_go) begin
          t0_high <= 8'(t0_high + `BYTE_ONE);
        end
      end else if (t0_low_go) begin
        {t0_high, t0_low} <= t0_step[15:0];
      end
      if (is_write(reg_req, `ADDR_T0_LOW)) begin
        t0_low <= reg_req.wdata;
      end
      if (is_write(reg_req, `ADDR_T0_HIGH)) begin
        t0_high <= reg_req.wdata;
      end
    end
  end

  // ************************************************************
  // timer 1 count bytes and baud tick
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      t1_low <= `RESET_BYTE;
      t1_high <= `RESET_BYTE;
    end else begin
      if (t1_go) begin
        {t1_high, t1_low} <= t1_step[15:0];
      end
      if (is_write(reg_req, `ADDR_T1_LOW)) begin
        t1_low <= reg_req.wdata;
      end
      if (is_write(reg_req, `ADDR_T1_HIGH)) begin
        t1_high <= reg_req.wdata;
      end
    end
  end

  // serial port keeps its clock even when timer 1 has no flag of its own
  always_ff @(posedge clock) begin
    if (rst) begin
      timer1_baud_tick <= 1'b0;
    end else begin
      timer1_baud_tick <= t1_ovf_evt;
    end
  end

  // ************************************************************
  // timer 2 function select and count
  // ************************************************************
  always_comb begin
    if (timer2_mode_register.timer2_clock_output_enable & ~timer2_control_register.capture_reload_select) begin
      t2_func = t2_clock_out;
    end else if (timer2_control_register.serial_receive_clock_select |
                 timer2_control_register.serial_transmit_clock_select) begin
      t2_func = t2_baud;
    end else if (timer2_control_register.capture_reload_select) begin
      t2_func = t2_capture;
    end else begin
      t2_func = t2_reload;
    end
  end

  assign t2_go = pick_tick(timer2_control_register.timer2_source_select, ctrl.t2_div4, fall2, tick_fast,
                           tick_slow)
                 & timer2_control_register.timer2_run;
  // trigger pin steers direction when down counting, so it is no event then
  assign t2_trig = timer2_control_register.trigger_enable & fall_trig &
                   ~(t2_func == t2_reload && timer2_mode_register.down_enable);

  // next count, capture value and wrap event
  always_comb begin
    next_t2_count = t2_count;
    next_t2_cap = t2_cap;
    t2_wrap = 1'b0;
    if (t2_go) begin
      if (t2_func == t2_reload && timer2_mode_register.down_enable && ~trig_level) begin
        t2_wrap = (t2_count == t2_cap);
        next_t2_count = t2_wrap ? `WORD_ONES : 16'(t2_count - `WORD_ONE);
      end else begin
        t2_wrap = (t2_count == `WORD_ONES);
        next_t2_count = 16'(t2_count + `WORD_ONE);
        if (t2_wrap && t2_func != t2_capture) begin
          next_t2_count = t2_cap;
        end
      end
    end
    if (t2_trig) begin
      if (t2_func == t2_capture) begin
        next_t2_cap = t2_count;
      end else if (t2_func == t2_reload) begin
        next_t2_count = t2_cap;
      end
    end
  end

  // timer 2 count and capture/reload value; writes beat counting
  always_ff @(posedge clock) begin
    if (rst) begin
      t2_count <= `RESET_WORD;
      t2_cap <= `RESET_WORD;
    end else begin
      t2_count <= next_t2_count;
      t2_cap <= next_t2_cap;
      if (is_write(reg_req, `ADDR_T2_LOW)) begin
        t2_count[7:0] <= reg_req.wdata;
      end
      if (is_write(reg_req, `ADDR_T2_HIGH)) begin
        t2_count[15:8] <= reg_req.wdata;
      end
      if (is_write(reg_req, `ADDR_T2_CAP_LOW)) begin
        t2_cap[7:0] <= reg_req.wdata;
      end
      if (is_write(reg_req, `ADDR_T2_CAP_HIGH)) begin
        t2_cap[15:8] <= reg_req.wdata;
      end
    end
  end

  // baud tick on each wrap in baud mode, clock-out toggle on each wrap in clock-out mode
  always_ff @(posedge clock) begin
    if (rst) begin
      timer2_baud_tick <= 1'b0;
      clock_out <= 1'b0;
    end else begin
      timer2_baud_tick <= t2_wrap & (t2_func == t2_baud);
      if (t2_wrap && t2_func == t2_clock_out) begin
        clock_out <= ~clock_out;
      end
    end
  end

  assign count_pin_two_out = clock_out;
  assign count_pin_two_oe = (t2_func == t2_clock_out);

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= '0;
      timer_mode_register <= '0;
      timer2_control_register <= '0;
      timer2_mode_register <= '0;
      mask <= '0;
    end else begin
      if (is_write(reg_req, `ADDR_CTRL)) begin
        ctrl <= ctrl_reg_s'(reg_req.wdata[4:0]);
      end
      if (is_write(reg_req, `ADDR_MODE)) begin
        timer_mode_register <= mode_reg_s'(reg_req.wdata);
      end
      if (is_write(reg_req, `ADDR_T2_CTRL)) begin
        timer2_control_register <= t2_ctrl_s'(reg_req.wdata[5:0]);
      end
      if (is_write(reg_req, `ADDR_T2_MODE)) begin
        timer2_mode_register <= t2_mode_s'(reg_req.wdata[1:0]);
      end
      if (is_write(reg_req, `ADDR_MASK)) begin
        mask <= irq_s'(reg_req.wdata[3:0]);
      end
    end
  end

  // ************************************************************
  // interrupt status: sticky, write one to clear, set wins
  // ************************************************************
  always_comb begin
    events.timer0_overflow_flag = t0_flag_evt;
    // split high byte owns timer 1's flag, timer 1 itself no longer does
    events.timer1_overflow_flag = t0_split ? t0_high_evt : t1_ovf_evt;
    events.t2_overflow = t2_wrap & (t2_func == t2_reload || t2_func == t2_capture);
    events.t2_trigger = t2_trig;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      status <= '0;
    end else if (is_write(reg_req, `ADDR_STATUS)) begin
      status <= (status & ~irq_s'(reg_req.wdata[3:0])) | events;
    end else begin
      status <= status | events;
    end
  end

  assign irq = |(status & mask);

  // ************************************************************
  // read data, valid only in the cycle after the read strobe
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst || !reg_req.rd) begin
      reg_rdata <= `RESET_BYTE;
    end else if (reg_req.addr == `ADDR_CTRL) begin
      reg_rdata <= {3'b000, ctrl};
    end else if (reg_req.addr == `ADDR_MODE) begin
      reg_rdata <= timer_mode_register;
    end else if (reg_req.addr == `ADDR_T0_LOW) begin
      reg_rdata <= t0_low;
    end else if (reg_req.addr == `ADDR_T0_HIGH) begin
      reg_rdata <= t0_high;
    end else if (reg_req.addr == `ADDR_T1_LOW) begin
      reg_rdata <= t1_low;
    end else if (reg_req.addr == `ADDR_T1_HIGH) begin
      reg_rdata <= t1_high;
    end else if (reg_req.addr == `ADDR_T2_CTRL) begin
      reg_rdata <= {2'b00, timer2_control_register};
    end else if (reg_req.addr == `ADDR_T2_MODE) begin
      reg_rdata <= {6'b000000, timer2_mode_register};
    end else if (reg_req.addr == `ADDR_T2_LOW) begin
      reg_rdata <= t2_count[7:0];
    end else if (reg_req.addr == `ADDR_T2_HIGH) begin
      reg_rdata <= t2_count[15:8];
    end else if (reg_req.addr == `ADDR_T2_CAP_LOW) begin
      reg_rdata <= t2_cap[7:0];
    end else if (reg_req.addr == `ADDR_T2_CAP_HIGH) begin
      reg_rdata <= t2_cap[15:8];
    end else if (reg_req.addr == `ADDR_STATUS) begin
      reg_rdata <= {4'h0, status};
    end else if (reg_req.addr == `ADDR_MASK) begin
      reg_rdata <= {4'h0, mask};
    end else begin
      reg_rdata <= `RESET_BYTE; // unmapped reads as zero
    end
  end
endmodule

/* test/timer_block_sva.sv */
// port checker for the split and up/down timer block
`timescale 1ns/1ps
`include "timer_defs.svh"
module timer_block_chk (
  input wire logic clock,
  input wire logic rst,
  input wire timer_pkg::reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic count_pin_two_out,
  input wire logic count_pin_two_oe,
  input wire logic timer1_baud_tick,
  input wire logic timer2_baud_tick,
  input wire logic irq
);
  import timer_pkg::*;
  logic [7:0] m;
  logic [7:0] t2c;
  logic [7:0] t2m;
  logic [3:0] k;
  logic bsel;
  logic t1frz;
  // ************************************************************
  // shadows of written settings
  // ************************************************************
  // kept here so outputs can be tied to what software asked for
  always_ff @(posedge clock) begin
    if (rst) begin
      m <= 8'h00;
      t2c <= 8'h00;
      t2m <= 8'h00;
      k <= 4'h0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == `ADDR_MODE) m <= reg_req.wdata;
      if (reg_req.addr == `ADDR_T2_CTRL) t2c <= reg_req.wdata;
      if (reg_req.addr == `ADDR_T2_MODE) t2m <= reg_req.wdata;
      if (reg_req.addr == `ADDR_MASK) k <= reg_req.wdata[3:0];
    end
  end
  // baud only without clock out, which has priority
  assign bsel = (t2c[5] || t2c[4]) && !(t2m[1] && !t2c[0]);
  assign t1frz = m[5:4] == 2'b11;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_rdata_idle:
    assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00) else $error("read data out of slot");
  chk_mask_readback:
    assert property ($past(reg_req.rd) && $past(reg_req.addr) == `ADDR_MASK |-> reg_rdata == {4'h0, k})
      else $error("mask readback wrong");
  chk_t2_mode_read:
    assert property ($past(reg_req.rd) && $past(reg_req.addr) == `ADDR_T2_MODE |-> reg_rdata == {6'h00, t2m[1:0]})
      else $error("timer 2 mode readback wrong");
  chk_oe_clock_out:
    assert property (count_pin_two_oe == (t2m[1] && !t2c[0])) else $error("clock out enable wrong");
  chk_baud_source:
    assert property (timer2_baud_tick |-> $past(bsel) || $past(bsel, 2)) else $error("baud tick outside baud mode");
  chk_t2_run_gate:
    assert property (!t2c[2] && !$past(t2c[2]) && !$past(t2c[2], 2) |-> !timer2_baud_tick)
      else $error("timer 2 ticks while stopped");
  chk_t1_frozen:
    assert property (t1frz && $past(t1frz) && $past(t1frz, 2) |-> !timer1_baud_tick)
      else $error("timer 1 overflows while frozen");
  chk_clkout_toggle:
    assert property ($changed(count_pin_two_out) |-> $past(count_pin_two_oe) || $past(count_pin_two_oe, 2))
      else $error("clock out toggles outside its mode");
  chk_irq_masked:
    assert property (k == 4'h0 |-> !irq) else $error("interrupt with all masked");
endmodule

bind timer_block timer_block_chk u_chk (.clock(clock), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .count_pin_two_out(count_pin_two_out), .count_pin_two_oe(count_pin_two_oe),
  .timer1_baud_tick(timer1_baud_tick), .timer2_baud_tick(timer2_baud_tick), .irq(irq));

/* test/ext_pins.sv */
// model of the external count, gate and trigger pins
`timescale 1ns/1ps
`include "timer_defs.svh"
module ext_pins (
  input wire logic clock,
  output logic count_pin_zero,
  output logic count_pin_one,
  output logic count_pin_two,
  output logic gate_pin_zero,
  output logic gate_pin_one,
  output logic trigger_pin_two
);
  logic [3:0] p;
  assign count_pin_zero = p[0];
  assign count_pin_one = p[1];
  assign count_pin_two = p[2];
  assign trigger_pin_two = p[3];
  // pins idle high, gates open
  initial begin
    p = {4{`PIN_IDLE}};
    gate_pin_zero = 1'b1;
    gate_pin_one = 1'b1;
  end
  // low and high phases of three cycles outlast the two-flop sync
  task pulse(input int i, input int n);
    for (int j = 0; j < n; j++) begin
      @(posedge clock);
      p[i] <= 1'b0;
      repeat (3) @(posedge clock);
      p[i] <= 1'b1;
      repeat (3) @(posedge clock);
    end
  endtask
  task gate(input logic a);
    @(posedge clock);
    gate_pin_zero <= a;
    gate_pin_one <= a;
  endtask
endmodule

/* test/timer_block_tb_top.sv */
// self-checking testbench of the split and up/down timer block
`timescale 1ns/1ps
`include "timer_defs.svh"
module timer_block_tb_top;
  import timer_pkg::*;
  logic clock;
  logic rst;
  reg_req_s reg_req;
  logic [7:0] reg_rdata;
  logic c0, c1, c2, g0, g1, tr, po, oe, b1, b2, irq;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int n1 = 0;
  int n2 = 0;
  int ntog = 0;
  int seed;
  logic last;
  logic [7:0] d;
  logic [7:0] h;
  ext_pins pins (.clock(clock), .count_pin_zero(c0), .count_pin_one(c1), .count_pin_two(c2),
    .gate_pin_zero(g0), .gate_pin_one(g1), .trigger_pin_two(tr));
  timer_block dut (.clock(clock), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .count_pin_zero(c0), .count_pin_one(c1), .count_pin_two(c2), .count_pin_two_out(po),
    .count_pin_two_oe(oe), .gate_pin_zero(g0), .gate_pin_one(g1), .trigger_pin_two(tr),
    .timer1_baud_tick(b1), .timer2_baud_tick(b2), .irq(irq));
  // ************************************************************
  // clock, monitors and helpers
  // ************************************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // sampled mid-cycle so registered outputs have settled
  always @(negedge clock) begin
    cyc++;
    if (b1 === 1'b1) n1++;
    if (b2 === 1'b1) n2++;
    if (po !== last) ntog++;
    last = po;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    reg_req.wr <= 1'b0;
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] e, input logic cmp = 1'b1);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    reg_req.rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    if (cmp) chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
  endtask
  // the low byte restarts at the reload value and may step a few times after
  function logic in_win(input logic [7:0] hv, input logic [7:0] lv);
    return lv >= hv && lv - hv < 8'h08;
  endfunction
  initial begin
    seed = 32'h4b04_c9c8;
    reg_req = '0;
    rst = 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rdc(`ADDR_MODE, 8'h00);
    wr(4'hf, 8'hff);
    rdc(4'hf, 8'h00);
    wr(`ADDR_T0_LOW, 8'hfe);
    wr(`ADDR_T0_HIGH, 8'hff);
    wr(`ADDR_MODE, 8'h01);
    wr(`ADDR_CTRL, 8'h05);
    repeat (40) @(posedge clock);
    wr(`ADDR_CTRL, 8'h00);
    rdc(`ADDR_T0_HIGH, 8'h00);
    rdc(`ADDR_STATUS, 8'h01);
    wr(`ADDR_MASK, 8'h01);
    @(negedge clock);
    chk("irq", 1, irq);
    wr(`ADDR_STATUS, 8'h0f);
    @(negedge clock);
    chk("irq", 0, irq);
    wr(`ADDR_MASK, 8'h00);
    wr(`ADDR_MODE, 8'h02);
    for (int i = 0; i < 3; i++) begin
      h = 8'($random(seed)) & 8'h7f;
      wr(`ADDR_T0_HIGH, h);
      wr(`ADDR_T0_LOW, 8'hff);
      wr(`ADDR_CTRL, 8'h05);
      repeat (12) @(posedge clock);
      wr(`ADDR_CTRL, 8'h00);
      rdc(`ADDR_T0_LOW, 8'h00, 1'b0);
      chk("reload", 1, in_win(h, d));
      rdc(`ADDR_T0_HIGH, h);
    end
    rdc(`ADDR_STATUS, 8'h01);
    // split: high byte on timer 1 run, low byte idle
    wr(`ADDR_STATUS, 8'h0f);
    wr(`ADDR_T1_LOW, 8'h33);
    wr(`ADDR_T0_LOW, 8'h80);
    wr(`ADDR_T0_HIGH, 8'hfe);
    wr(`ADDR_MODE, 8'h33);
    wr(`ADDR_CTRL, 8'h06);
    repeat (40) @(posedge clock);
    wr(`ADDR_CTRL, 8'h04);
    rdc(`ADDR_STATUS, 8'h02);
    rdc(`ADDR_T0_LOW, 8'h80);
    rdc(`ADDR_T1_LOW, 8'h33);
    // split low byte counts pin falls, then is gated off
    wr(`ADDR_T0_LOW, 8'hfe);
    wr(`ADDR_MODE, 8'h37);
    wr(`ADDR_CTRL, 8'h01);
    pins.pulse(0, 3);
    wr(`ADDR_MODE, 8'h3f);
    pins.gate(1'b0);
    pins.pulse(0, 2);
    pins.gate(1'b1);
    rdc(`ADDR_T0_LOW, 8'h01);
    rdc(`ADDR_STATUS, 8'h03);
    // timer 1 runs in mode 1 without its run bit or flag
    wr(`ADDR_STATUS, 8'h0f);
    wr(`ADDR_T1_LOW, 8'hfe);
    wr(`ADDR_T1_HIGH, 8'hff);
    wr(`ADDR_MODE, 8'h13);
    wr(`ADDR_CTRL, 8'h08);
    repeat (20) @(posedge clock);
    wr(`ADDR_MODE, 8'h33);
    rdc(`ADDR_T1_HIGH, 8'h00);
    chk("t1 ticks", 1, n1 > 0);
    rdc(`ADDR_STATUS, 8'h00);
    // timer 2 baud mode on pin falls, then stopped
    wr(`ADDR_T2_CAP_LOW, 8'hfe);
    wr(`ADDR_T2_CAP_HIGH, 8'hff);
    wr(`ADDR_T2_LOW, 8'hfe);
    wr(`ADDR_T2_HIGH, 8'hff);
    wr(`ADDR_T2_CTRL, 8'h16);
    pins.pulse(2, 2);
    chk("t2 ticks", 1, n2 == 1);
    rdc(`ADDR_T2_LOW, 8'hfe);
    wr(`ADDR_T2_CTRL, 8'h12);
    pins.pulse(2, 3);
    rdc(`ADDR_T2_LOW, 8'hfe);
    // clock out wins over a serial select
    wr(`ADDR_T2_MODE, 8'h02);
    wr(`ADDR_T2_CTRL, 8'h14);
    wr(`ADDR_CTRL, 8'h10);
    ntog = 0;
    repeat (40) @(negedge clock);
    chk("oe", 1, oe);
    chk("toggles", 1, ntog >= 3 && n2 == 1);
    // capture copies the count on a trigger fall
    wr(`ADDR_T2_MODE, 8'h00);
    wr(`ADDR_T2_LOW, 8'h00);
    wr(`ADDR_T2_HIGH, 8'h00);
    wr(`ADDR_STATUS, 8'h0f);
    wr(`ADDR_T2_CTRL, 8'h0d);
    pins.pulse(3, 1);
    rdc(`ADDR_STATUS, 8'h08);
    rdc(`ADDR_T2_CAP_HIGH, 8'h00);
    // auto-reload from a random reload value on pin falls
    wr(`ADDR_T2_CTRL, 8'h02);
    h = 8'($random(seed));
    wr(`ADDR_T2_CAP_LOW, h);
    wr(`ADDR_T2_LOW, 8'hfe);
    wr(`ADDR_T2_HIGH, 8'hff);
    wr(`ADDR_T2_CTRL, 8'h06);
    pins.pulse(2, 2);
    rdc(`ADDR_T2_LOW, h);
    rdc(`ADDR_STATUS, 8'h0c);
    close_out();
  end
endmodule
